// [hdl/dp_fix_params.svh]
`ifndef DP_FIX_PARAMS_SVH
`define DP_FIX_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave.
`define OFS_MODE          4'h0
`define OFS_ARITH         4'h4
`define OFS_STICKY        4'h8
`define OFS_RESULT        4'hc

// Field positions in core_mode_control.
`define MODE_TRUNCATE     0
`define MODE_SATURATE     1
`define MODE_SHORT_WIDTH  2
`define MODE_WIDTH        3
`define MODE_RESET        3'h0

// Field positions in arith_status.
`define AST_ZERO          0
`define AST_NEG           1
`define AST_OVF           2
`define AST_CARRY         3
`define AST_SIGN          4
`define AST_INV           5
`define AST_WIDTH         6
`define AST_RESET         6'h00

// Field positions in sticky_status.
`define STK_UNDER         0
`define STK_OUT_OVF       1
`define STK_OVF           2
`define STK_INV           3
`define STK_WIDTH         4
`define STK_RESET         4'h0

// Datapath constants.
`define EXP_BIAS          34'sh000003ff
`define EXP_ALL_ONES      11'h7ff
`define INT_MAX           32'h7fffffff
`define INT_MIN           32'h80000000
`define INT_ONES          32'hffffffff
`define EXT_ONES          8'hff
`define EXEC_CYCLES       4

`endif

// [hdl/dp_fix_pkg.sv]
package dp_fix_pkg;

  // Operation selected by the instruction decoder.
  typedef enum logic [1:0] {
    OP_FIX,
    OP_FIX_SCALED,
    OP_TRUNC,
    OP_TRUNC_SCALED
  } fix_op_e;

  // Rounding applied to the mantissa.
  typedef enum logic [1:0] {
    RND_NEAREST,
    RND_FLOOR,
    RND_ZERO
  } round_mode_e;

endpackage : dp_fix_pkg

// [hdl/dp_float_to_fixed_convert.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dp_fix_params.svh"

// What this block does
// - Converts double operand to signed 32-bit integer.
// - Scaled ops add scale to exponent first.
// - Result right-justified in destination fixed field.
// - Destination extension field zero, except NaN with short-width bit clear.
// - Fix floors when truncate set, else nearest.
// - Trunc ops always round toward zero.
// - Saturation clamps to max or min integer.
// - Without saturation, overflow or infinity gives ones.
// - Underflow gives zero, minus one when flooring negative.
// - Denormal input treated as signed zero.
// - NaN gives ones, width from short-width bit.
// - Result and status written after four cycles.
// - Invalid flag for NaN, or unsaturated overflow.
// - Negative flag from result; carry, sign cleared.
// - Overflow flag for pre-rounded range miss or infinity.
// - Zero flag set exactly for zero result.
// - Sticky underflow for nonzero magnitude below one.
// - Sticky invalid and overflow follow their flags.
module dp_float_to_fixed_convert
  import dp_fix_pkg::*;
#(
  parameter int LATENCY = `EXEC_CYCLES
) (
  input  wire logic        clk,            // Core clock.
  input  wire logic        reset_n,        // Async reset, active low.
  input  wire logic        opValid,        // Operation issued this cycle.
  input  wire fix_op_e     opCode,         // Operation selector.
  input  wire logic [63:0] doubleSourcePair, // Double operand.
  input  wire logic [31:0] scaleSource,    // Signed exponent scale.
  output logic             resultValid,    // Destination write strobe.
  output logic      [39:0] integerDestination, // Destination value.
  output logic       [5:0] arithStatus,    // Arithmetic status flags.
  output logic       [3:0] stickyStatus,   // Sticky status flags.
  input  wire logic  [3:0] address,        // Avalon byte address.
  input  wire logic        read,           // Avalon read.
  input  wire logic        write,          // Avalon write.
  input  wire logic  [3:0] byteenable,     // Avalon byte enables.
  input  wire logic [31:0] writedata,      // Avalon write data.
  output logic      [31:0] readdata,       // Avalon read data.
  output logic             waitrequest     // Avalon wait request.
);

  ////////////////////////////////////////////////////////////////////
  // Register bus slave.

  logic                    ackFf;
  logic             [31:0] rdDataFf;
  logic [`MODE_WIDTH-1:0]  modeFf;
  logic [`AST_WIDTH-1:0]   arithFf;
  logic [`STK_WIDTH-1:0]   stickyFf;
  logic             [39:0] resPipe [LATENCY];
  logic              [2:0] flagPipe [LATENCY];
  logic      [LATENCY-1:0] vPipe;
  logic                    busReq;
  logic                    busDone;
  logic                    wrMode;
  logic                    wrSticky;
  logic             [31:0] nxt_rdData;

  // Every access waits exactly one cycle, then completes.
  assign busReq      = read | write;
  assign waitrequest = busReq & ~ackFf;
  assign busDone     = busReq & ackFf;
  assign wrMode      = busDone & write & byteenable[0] &
                       (address == `OFS_MODE);
  assign wrSticky    = busDone & write & byteenable[0] &
                       (address == `OFS_STICKY);
  assign readdata    = rdDataFf;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ackFf <= 1'b0;
    end else begin
      ackFf <= busReq & ~ackFf;
    end
  end

  // Unmapped offsets read as zero.
  always_comb begin
    nxt_rdData = 32'h0;
    unique case (address)
      `OFS_MODE:   nxt_rdData[`MODE_WIDTH-1:0] = modeFf;
      `OFS_ARITH:  nxt_rdData[`AST_WIDTH-1:0]  = arithFf;
      `OFS_STICKY: nxt_rdData[`STK_WIDTH-1:0]  = stickyFf;
      `OFS_RESULT: nxt_rdData = resPipe[LATENCY-1][31:0];
      default:     nxt_rdData = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdDataFf <= 32'h0;
    end else if (busReq & ~ackFf & read) begin
      rdDataFf <= nxt_rdData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeFf <= `MODE_RESET;
    end else if (wrMode) begin
      modeFf <= writedata[`MODE_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operand decode and conversion.

  logic              opSign;
  logic       [10:0] opExp;
  logic       [51:0] opFrac;
  logic       [52:0] mant;
  logic              isNan;
  logic              isInf;
  logic              isZero;
  logic              scaled;
  logic signed [33:0] expSum;
  logic              exactMin;
  logic              preOvf;
  logic              under;
  logic        [5:0] sh;
  logic       [52:0] intMag;
  logic       [52:0] remBits;
  logic       [52:0] half;
  logic              inc;
  logic       [32:0] magR;
  logic              postOvf;
  logic              ovfRes;
  logic       [31:0] fixed;
  logic       [39:0] nxt_res;
  logic              nxt_inv;
  logic              nxt_ovf;
  logic              nxt_under;
  round_mode_e       rmode;

  // Decides whether the truncated magnitude steps up by one.
  function automatic logic round_up(
    input round_mode_e mode,
    input logic        neg,
    input logic [52:0] rem,
    input logic [52:0] hlf,
    input logic        lsb
  );
    unique case (mode)
      RND_FLOOR:   round_up = neg & (rem != 53'h0);
      RND_NEAREST: round_up = (rem > hlf) | ((rem == hlf) & lsb);
      RND_ZERO:    round_up = 1'b0;
      default:     round_up = 1'b0;
    endcase
  endfunction : round_up

  assign opSign = doubleSourcePair[63];
  assign opExp  = doubleSourcePair[62:52];
  assign opFrac = doubleSourcePair[51:0];
  assign mant   = {1'b1, opFrac};
  assign isNan  = (opExp == `EXP_ALL_ONES) & (opFrac != 52'h0);
  assign isInf  = (opExp == `EXP_ALL_ONES) & (opFrac == 52'h0);
  assign isZero = (opExp == 11'h0);
  assign scaled = (opCode == OP_FIX_SCALED) | (opCode == OP_TRUNC_SCALED);

  always_comb begin
    rmode = RND_NEAREST;
    if ((opCode == OP_TRUNC) | (opCode == OP_TRUNC_SCALED)) begin
      rmode = RND_ZERO;
    end else if (modeFf[`MODE_TRUNCATE]) begin
      rmode = RND_FLOOR;
    end
  end

  always_comb begin
    expSum = $signed({23'h0, opExp}) - `EXP_BIAS;
    if (scaled) begin
      expSum = expSum + $signed({{2{scaleSource[31]}}, scaleSource});
    end
  end

  // A value of exactly minus two to the 31st still fits.
  assign exactMin = (expSum == 34'sd31) & (opFrac == 52'h0) & opSign;
  assign preOvf   = ~isZero & (expSum > 34'sd30) & ~exactMin;
  assign under    = ~isZero & (expSum < 34'sd0);
  assign sh       = 6'd52 - expSum[5:0];
  assign intMag   = mant >> sh;
  assign remBits  = mant & ~({53{1'b1}} << sh);
  assign half     = 53'h1 << (sh - 6'd1);
  assign inc      = round_up(rmode, opSign, remBits, half, intMag[0]);
  assign magR     = exactMin ? 33'h080000000 : intMag[32:0] + {32'h0, inc};
  assign postOvf  = opSign ? (magR > 33'h080000000) : magR[32] | magR[31];
  assign ovfRes   = isInf | preOvf | (~under & ~isZero & postOvf);

  always_comb begin
    fixed = opSign ? 32'h0 - magR[31:0] : magR[31:0];
    if (isZero) begin
      fixed = 32'h0;
    end else if (under) begin
      fixed = (opSign & (rmode == RND_FLOOR)) ? `INT_ONES : 32'h0;
    end
    if (ovfRes) begin
      if (modeFf[`MODE_SATURATE]) begin
        fixed = opSign ? `INT_MIN : `INT_MAX;
      end else begin
        fixed = `INT_ONES;
      end
    end
  end

  always_comb begin
    nxt_res = {8'h0, fixed};
    if (isNan) begin
      nxt_res[31:0] = `INT_ONES;
      if (!modeFf[`MODE_SHORT_WIDTH]) begin
        nxt_res[39:32] = `EXT_ONES;
      end
    end
  end

  assign nxt_inv   = isNan | (~isNan & ovfRes & ~modeFf[`MODE_SATURATE]);
  assign nxt_ovf   = ~isNan & (isInf | preOvf);
  assign nxt_under = ~isNan & ~isInf & under;

  ////////////////////////////////////////////////////////////////////
  // Execution pipeline.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vPipe <= '0;
    end else begin
      vPipe <= {vPipe[LATENCY-2:0], opValid};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        resPipe[i]  <= 40'h0;
        flagPipe[i] <= 3'h0;
      end
    end else begin
      // Stages load only with a live operation, so the destination holds between results.
      if (opValid) begin
        resPipe[0]  <= nxt_res;
        flagPipe[0] <= {nxt_under, nxt_ovf, nxt_inv};
      end
      for (int i = 1; i < LATENCY; i++) begin
        if (vPipe[i-1]) begin
          resPipe[i]  <= resPipe[i-1];
          flagPipe[i] <= flagPipe[i-1];
        end
      end
    end
  end

  assign resultValid        = vPipe[LATENCY-1];
  assign integerDestination = resPipe[LATENCY-1];

  ////////////////////////////////////////////////////////////////////
  // Status registers, written with the destination.

  logic        lastWrite;
  logic [39:0] lastRes;
  logic  [2:0] lastFlags;

  assign lastWrite = vPipe[LATENCY-2];
  assign lastRes   = resPipe[LATENCY-2];
  assign lastFlags = flagPipe[LATENCY-2];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arithFf <= `AST_RESET;
    end else if (lastWrite) begin
      arithFf[`AST_ZERO]  <= (lastRes[31:0] == 32'h0);
      arithFf[`AST_NEG]   <= lastRes[31];
      arithFf[`AST_OVF]   <= lastFlags[1];
      arithFf[`AST_CARRY] <= 1'b0;
      arithFf[`AST_SIGN]  <= 1'b0;
      arithFf[`AST_INV]   <= lastFlags[0];
    end
  end

  // A set in the same cycle as a software write wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stickyFf <= `STK_RESET;
    end else begin
      stickyFf <= (wrSticky ? writedata[`STK_WIDTH-1:0] : stickyFf) |
                  ({`STK_WIDTH{lastWrite}} &
                   {lastFlags[0], lastFlags[1], 1'b0, lastFlags[2]});
    end
  end

  assign arithStatus  = arithFf;
  assign stickyStatus = stickyFf;

  ////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_issue_nan;
    opValid & isNan;
  endsequence

  sequence s_issue_sat_pos_inf;
    opValid & isInf & ~opSign & modeFf[`MODE_SATURATE];
  endsequence

  sequence s_issue_denormal;
    opValid & isZero;
  endsequence

  property p_latency;
    @(posedge clk) disable iff (!reset_n)
      opValid |-> ##4 resultValid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("Result not written four cycles after issue.");

  property p_nan_ones;
    @(posedge clk) disable iff (!reset_n)
      s_issue_nan |-> ##4 (integerDestination[31:0] == 32'hffffffff);
  endproperty
  a_nan_ones: assert property (p_nan_ones)
    else $error("NaN did not give an all-ones result.");

  property p_sat_pos;
    @(posedge clk) disable iff (!reset_n)
      s_issue_sat_pos_inf ##1 !wrMode[*3]
        |-> ##1 (integerDestination[31:0] == 32'h7fffffff);
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("Saturated positive infinity not clamped to max.");

  property p_denormal_zero;
    @(posedge clk) disable iff (!reset_n)
      s_issue_denormal |-> ##4 ((integerDestination == 40'h0) && arithStatus[0]);
  endproperty
  a_denormal_zero: assert property (p_denormal_zero)
    else $error("Denormal input did not convert to zero.");

  property p_ext_zero;
    @(posedge clk) disable iff (!reset_n)
      resultValid & (integerDestination[31:0] != 32'hffffffff)
        |-> (integerDestination[39:32] == 8'h0);
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("Extension field not zero.");

  property p_zero_flag;
    @(posedge clk) disable iff (!reset_n)
      resultValid |-> (arithStatus[0] == (integerDestination[31:0] == 32'h0));
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("Zero flag disagrees with result.");

  property p_neg_flag;
    @(posedge clk) disable iff (!reset_n)
      resultValid |-> (arithStatus[1] == integerDestination[31]) &&
                      (arithStatus[4:3] == 2'b00);
  endproperty
  a_neg_flag: assert property (p_neg_flag)
    else $error("Negative, carry or sign flag wrong.");

  property p_sticky_follow;
    @(posedge clk) disable iff (!reset_n)
      resultValid |-> (!arithStatus[5] || stickyStatus[3]) &&
                      (!arithStatus[2] || stickyStatus[2]);
  endproperty
  a_sticky_follow: assert property (p_sticky_follow)
    else $error("Sticky flag did not follow its status flag.");

  property p_sticky_hold;
    @(posedge clk) disable iff (!reset_n)
      !$past(wrSticky) |-> ((stickyStatus & $past(stickyStatus)) == $past(stickyStatus));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("Sticky flag cleared without a software write.");

endmodule : dp_float_to_fixed_convert

`default_nettype wire

// [verification/decoder_model.sv]
`timescale 1ns/1ns
`default_nettype none
module decoder_model
  import dp_fix_pkg::*;
(
  input  wire logic        clk,                // Core clock.
  input  wire logic        resultValid,        // Destination write strobe.
  input  wire logic [39:0] integerDestination, // Result word.
  output logic             opValid,            // Issue strobe.
  output fix_op_e          opCode,             // Operation selector.
  output logic      [63:0] doubleSourcePair,   // Double operand.
  output logic      [31:0] scaleSource,        // Exponent scale.
  output logic      [39:0] capturedResult,     // Last result taken.
  output logic       [7:0] latency             // Negedges from issue to result.
);
  initial begin
    opValid          = 1'b0;
    opCode           = OP_FIX;
    doubleSourcePair = 64'h0;
    scaleSource      = 32'h0;
    capturedResult   = 40'h0;
    latency          = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issues one operation just after a rising edge and waits for its result.
  // Operands are inverted once taken, so a late sample shows a wrong value.
  task automatic issue(input fix_op_e op, input logic [63:0] d, input logic [31:0] s);
    opValid          <= 1'b1;
    opCode           <= op;
    doubleSourcePair <= d;
    scaleSource      <= s;
    @(posedge clk);
    opValid          <= 1'b0;
    doubleSourcePair <= ~d;
    scaleSource      <= ~s;
    latency = 8'h00;
    do begin
      @(negedge clk);
      latency = latency + 8'h01;
    end while (resultValid !== 1'b1 && latency < 8'h14);
    capturedResult = integerDestination;
  endtask : issue
endmodule : decoder_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
  import dp_fix_pkg::*;
;
  localparam int LAT = 4;
  logic        clk        = 1'b0;
  logic        reset_n    = 1'b0;
  logic  [3:0] address    = 4'h0;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic  [3:0] byteenable = 4'h0;
  logic [31:0] writedata  = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        resultValid;
  logic [39:0] integerDestination;
  logic  [5:0] arithStatus;
  logic  [3:0] stickyStatus;
  logic        opValid;
  fix_op_e     opCode;
  logic [63:0] doubleSourcePair;
  logic [31:0] scaleSource;
  logic [39:0] capturedResult;
  logic  [7:0] latency;
  logic  [2:0] modeVal    = 3'h0;
  logic  [3:0] stickyExp  = 4'h0;
  logic [31:0] seed       = 32'h00000040;
  logic [31:0] rd;
  logic [63:0] d;
  int          miscompares = 0;
  int          nTests      = 0;
  logic [63:0] corner [11] = '{64'h4004000000000000, 64'hc004000000000000,
    64'hbfe0000000000000, 64'h3fe8000000000000, 64'hc1e0000000000000,
    64'h41e0000000000000, 64'h41dfffffffe00000, 64'h7ff0000000000000,
    64'hfff0000000000000, 64'h7ff8000000000000, 64'h8000000000000001};

  always #20 clk = ~clk;

  dp_float_to_fixed_convert #(.LATENCY(LAT)) DUT (
    .clk(clk), .reset_n(reset_n), .opValid(opValid), .opCode(opCode),
    .doubleSourcePair(doubleSourcePair), .scaleSource(scaleSource),
    .resultValid(resultValid), .integerDestination(integerDestination),
    .arithStatus(arithStatus), .stickyStatus(stickyStatus), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));

  decoder_model partner (
    .clk(clk), .resultValid(resultValid), .integerDestination(integerDestination),
    .opValid(opValid), .opCode(opCode), .doubleSourcePair(doubleSourcePair),
    .scaleSource(scaleSource), .capturedResult(capturedResult), .latency(latency));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xorshift

  // Returns sticky bits to set, arith flags and result word, in that order.
  function automatic logic [49:0] predict(input fix_op_e op, input logic [2:0] m,
                                          input logic [63:0] v, input logic [31:0] s);
    real         x;
    real         r;
    logic [39:0] res;
    logic        ovf;
    logic        inv;
    logic        und;
    ovf = 1'b0;
    inv = 1'b0;
    und = 1'b0;
    if (v[62:52] == 11'h7ff && v[51:0] != 52'h0) begin
      res = m[2] ? 40'h00ffffffff : 40'hffffffffff;
      inv = 1'b1;
    end else begin
      if (v[62:52] == 11'h7ff) x = v[63] ? -1.0e300 : 1.0e300;
      else if (v[62:52] == 11'h000) x = 0.0;
      else if (op inside {OP_FIX_SCALED, OP_TRUNC_SCALED}) x = $bitstoreal(v) * (2.0 ** $signed(s));
      else x = $bitstoreal(v);
      und = (x != 0.0 && x > -1.0 && x < 1.0);
      ovf = (x >= 2147483648.0 || x < -2147483648.0);
      if (op inside {OP_TRUNC, OP_TRUNC_SCALED}) r = (x < 0.0) ? -$floor(-x) : $floor(x);
      else if (m[0]) r = $floor(x);
      else begin
        r = $floor(x + 0.5);
        if (r - x == 0.5 && $floor(r / 2.0) * 2.0 != r) r = r - 1.0;
      end
      if (und) r = (m[0] && op inside {OP_FIX, OP_FIX_SCALED} && x < 0.0) ? -1.0 : 0.0;
      if (ovf || r >= 2147483648.0) begin
        inv = ~m[1];
        res = m[1] ? (x > 0.0 ? 40'h007fffffff : 40'h0080000000) : 40'h00ffffffff;
      end else res = {8'h00, 32'($rtoi(r))};
    end
    return {inv, ovf, 1'b0, und, inv, 2'b00, ovf, res[31], res[31:0] == 32'h0, res};
  endfunction : predict

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (miscompares == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    byteenable <= be;
    writedata  <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
    rd    = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hf, 32'h0);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rdchk

  task automatic set_mode(input logic [2:0] m);
    modeVal = m;
    bus(1'b1, 4'h0, 4'hf, {29'h0, m});
  endtask : set_mode

  task automatic run_op(input fix_op_e op, input logic [63:0] v, input logic [31:0] s);
    logic [49:0] p;
    p = predict(op, modeVal, v, s);
    @(posedge clk);
    partner.issue(op, v, s);
    if (latency >= 8'h14) begin
      miscompares++;
      report_and_stop();
    end
    stickyExp = stickyExp | p[49:46];
    check({32'h0, latency}, 40'(LAT));
    check(capturedResult, p[39:0]);
    check({34'h0, arithStatus}, {34'h0, p[45:40]});
    check({36'h0, stickyStatus}, {36'h0, stickyExp});
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk(4'(i * 4), 32'h0);
    rdchk(4'h2, 32'h0);
    bus(1'b1, 4'h4, 4'hf, 32'hffffffff);
    rdchk(4'h4, 32'h0);
    bus(1'b1, 4'h0, 4'h0, 32'h00000007);
    rdchk(4'h0, 32'h0);
    bus(1'b1, 4'h8, 4'hf, 32'h0000000f);
    rdchk(4'h8, 32'h0000000f);
    bus(1'b1, 4'h8, 4'hf, 32'h0);
    rdchk(4'h8, 32'h0);
    for (int m = 0; m < 8; m++) begin
      set_mode(3'(m));
      rdchk(4'h0, 32'(m));
      foreach (corner[i])
        for (int o = 0; o < 4; o++) run_op(fix_op_e'(o), corner[i], 32'h1);
    end
    for (int k = 0; k < 400; k++) begin
      if (k % 8 == 0) begin
        seed = xorshift(seed);
        set_mode(seed[2:0]);
      end
      seed = xorshift(seed);
      d[63:32] = {seed[31], 11'h3e8 + {5'h0, seed[30:25]}, seed[19:0]};
      rd = 32'(int'(seed[23:20]) - 8);
      seed = xorshift(seed);
      d[31:0] = seed;
      run_op(fix_op_e'(seed[1:0]), d, rd);
    end
    bus(1'b1, 4'h8, 4'hf, 32'h0);
    stickyExp = 4'h0;
    rdchk(4'h8, 32'h0);
    run_op(OP_TRUNC, corner[0], 32'h0);
    rdchk(4'hc, 32'h00000002);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
